//--- verilog/bus_iface_map.vh
// constants for the processor bus interface block
`ifndef BUS_IFACE_MAP_VH
`define BUS_IFACE_MAP_VH
// apb register byte addresses
`define REG_CTRL 12'h000
`define REG_REQ 12'h004
`define REG_STAT 12'h008
`define REG_DATA 12'h00C
`define REG_VEC 12'h010
`define REG_PRIO 12'h014
// control register fields
`define CTRL_DYN 0
`define CTRL_LONG 1
`define CTRL_64K 2
`define CTRL_RST 16'h0000
// request register fields
`define REQ_ADDR_HI 15
`define REQ_KIND_LO 16
`define REQ_KIND_HI 18
`define REQ_FETCH 19
`define REQ_BYTE 20
`define REQ_STACK 21
// transaction kinds
`define K_READ 3'h0
`define K_WRITE 3'h1
`define K_PRIORITY_SAMPLE_CYCLE 3'h2
`define K_INTERRUPT_ACKNOWLEDGE 3'h3
`define K_NOP 3'h4
// vectors (octal values)
`define VEC_PF 16'o24
`define VEC_B7 16'o140
`define VEC_B6 16'o100
`define VEC_B5 16'o120
`define VEC_B4 16'o60
`define PSW_HALT 16'o340
`define RESTART_DEF 16'o172004
// phase codes
`define PH_IDLE 3'h0
`define PH_1 3'h1
`define PH_2 3'h2
`define PH_D 3'h3
`define PH_W 3'h4
`endif

//--- verilog/processor_bus_interface.v
// bus interface unit: transactions, interrupt decode and dma arbitration
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bus_iface_map.vh"
module processor_bus_interface (
   // clock and reset
   input wire clk,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // data/address lines
   input wire [15:0] dataAddressIn,
   output reg [15:0] dataAddressOut,
   output wire dataAddressOe,
   // address-interrupt lines
   input wire [7:0] addressInterruptIn,
   output reg [7:0] addressInterruptOut,
   output wire [7:0] addressInterruptOe,
   output wire addressInterruptPullup,
   // strobes and controls
   output reg rowStrobe_n,
   output reg columnStrobe_n,
   output reg priorityInStrobe,
   output reg writeHighByte_n,
   output reg writeLowByte_n,
   output wire writeControlOe,
   output reg [1:0] cycleCode,
   input wire ready
);
   reg [15:0] ctrl;
   reg [31:0] req;
   reg busy;
   reg [2:0] phase;
   reg micro;
   reg [2:0] kind;
   reg [15:0] addr;
   reg [15:0] wdata;
   reg [15:0] rdata;
   reg pendWrite;
   reg granted;
   reg dmaSeen;
   reg [15:0] vector;
   reg [15:0] pc;
   reg [15:0] processor_status_word;
   reg [2:0] irqLevel;
   reg irqPend;
   reg haltPend;
   reg pfPend;
   reg extVec;
   reg [3:0] cpLatched;
   reg done;
   wire access;
   wire [2:0] reqKind;
   wire needD;
   wire sampleIrq;
   assign access = psel & penable;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign reqKind = req[`REQ_KIND_HI:`REQ_KIND_LO];
   // float the data, address-interrupt and write control lines while granted
   // address stands while the row strobe leads; reads release the lines for the data
   assign dataAddressOe = ~granted & busy & (kind == `K_WRITE | phase == `PH_2);
   assign addressInterruptOe = (~granted & busy & ctrl[`CTRL_DYN] & phase == `PH_2) ?
      8'hFF : 8'h00;
   assign addressInterruptPullup = granted;
   assign writeControlOe = ~granted;
   assign needD = ctrl[`CTRL_LONG] | granted | kind == `K_PRIORITY_SAMPLE_CYCLE | kind == `K_INTERRUPT_ACKNOWLEDGE;
   assign sampleIrq = kind == `K_READ | kind == `K_PRIORITY_SAMPLE_CYCLE;

   // vector base for a coded priority level
   function [15:0] codedVector;
      input [3:0] cp;
      begin
         case (cp[3:2])
            2'b00: codedVector = `VEC_B7 + {10'h000, cp[1:0], 2'b00};
            2'b01: codedVector = `VEC_B6 + {10'h000, cp[1:0], 2'b00};
            2'b10: codedVector = `VEC_B5 + {10'h000, cp[1:0], 2'b00};
            default: codedVector = `VEC_B4 + {10'h000, cp[1:0], 2'b00};
         endcase
      end
   endfunction

   // scrambled dynamic address: row then column
   function [7:0] dynAddr;
      input [15:0] a;
      input col;
      input big;
      input fetch;
      begin
         if (!col) begin
            dynAddr = {a[13], a[11], a[9], a[7], a[5], a[3], a[1], big ? a[15] : fetch};
         end else begin
            dynAddr = {big ? a[12] : a[14], a[12], a[10], a[8], a[6], a[4], a[2], a[14]};
         end
      end
   endfunction

   // apb control register write and register read mux
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= `CTRL_RST;
         prdata <= 32'h00000000;
      end else begin
         if (access && pwrite && paddr == `REG_CTRL) begin
            ctrl <= pwdata[15:0];
         end
         if (psel && !penable && !pwrite) begin
            if (paddr == `REG_CTRL) begin
               prdata <= {16'h0000, ctrl};
            end else if (paddr == `REG_REQ) begin
               prdata <= req;
            end else if (paddr == `REG_STAT) begin
               prdata <= {19'h00000, irqPend, haltPend, pfPend, extVec, dmaSeen,
                  granted, pendWrite, busy, 1'b0, phase, done};
            end else if (paddr == `REG_DATA) begin
               prdata <= {16'h0000, rdata};
            end else if (paddr == `REG_VEC) begin
               prdata <= {pc, vector};
            end else if (paddr == `REG_PRIO) begin
               prdata <= {13'h0000, irqLevel, processor_status_word};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

   // transaction sequencer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         req <= 32'h00000000;
         busy <= 1'b0;
         phase <= `PH_IDLE;
         micro <= 1'b0;
         kind <= `K_NOP;
         addr <= 16'h0000;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
         pendWrite <= 1'b0;
         granted <= 1'b0;
         dmaSeen <= 1'b0;
         vector <= 16'h0000;
         pc <= 16'h0000;
         processor_status_word <= 16'h0000;
         irqLevel <= 3'h0;
         irqPend <= 1'b0;
         haltPend <= 1'b0;
         pfPend <= 1'b0;
         extVec <= 1'b0;
         cpLatched <= 4'hF;
         done <= 1'b0;
         dataAddressOut <= 16'h0000;
         addressInterruptOut <= 8'h00;
         rowStrobe_n <= 1'b1;
         columnStrobe_n <= 1'b1;
         priorityInStrobe <= 1'b0;
         writeHighByte_n <= 1'b1;
         writeLowByte_n <= 1'b1;
         cycleCode <= 2'b00;
      end else begin
         if (access && pwrite && paddr == `REG_PRIO) begin
            processor_status_word <= pwdata[15:0];
         end
         if (access && pwrite && paddr == `REG_REQ && !busy) begin
            req <= pwdata;
            // a write without REQ_STACK set first runs the read
            pendWrite <= pwdata[`REQ_KIND_HI:`REQ_KIND_LO] == `K_WRITE &&
               !pwdata[`REQ_STACK];
            kind <= (pwdata[`REQ_KIND_HI:`REQ_KIND_LO] == `K_WRITE && !pwdata[`REQ_STACK]) ?
               `K_READ : pwdata[`REQ_KIND_HI:`REQ_KIND_LO];
            addr <= pwdata[`REQ_ADDR_HI:0];
            busy <= 1'b1;
            micro <= 1'b0;
            done <= 1'b0;
            phase <= `PH_1;
         end
         if (access && pwrite && paddr == `REG_DATA) begin
            wdata <= pwdata[15:0];
         end
         case (phase)
            `PH_1: begin
               dataAddressOut <= addr;
               addressInterruptOut <= dynAddr(addr, 1'b0, ctrl[`CTRL_64K], req[`REQ_FETCH]);
               rowStrobe_n <= 1'b0;
               cycleCode <= granted ? 2'b11 : (req[`REQ_FETCH] ? 2'b01 : 2'b00);
               phase <= `PH_2;
            end
            `PH_2: begin
               addressInterruptOut <= dynAddr(addr, 1'b1, ctrl[`CTRL_64K], req[`REQ_FETCH]);
               columnStrobe_n <= 1'b0;
               if (kind == `K_WRITE) begin
                  dataAddressOut <= wdata;
                  writeHighByte_n <= req[`REQ_BYTE] & ~addr[0];
                  writeLowByte_n <= addr[0];
               end
               priorityInStrobe <= 1'b1;
               phase <= needD ? `PH_D : `PH_W;
            end
            `PH_D: begin
               // acknowledge cycles wait on ready
               if (kind != `K_INTERRUPT_ACKNOWLEDGE || ready) begin
                  phase <= `PH_W;
               end
            end
            `PH_W: begin
               dmaSeen <= addressInterruptIn[0];
               if (granted && !addressInterruptIn[0]) begin
                  granted <= 1'b0;
               end
               if (!granted && sampleIrq) begin
                  haltPend <= ~addressInterruptIn[7];
                  pfPend <= ~addressInterruptIn[6];
                  extVec <= ~addressInterruptIn[5];
                  irqPend <= addressInterruptIn[4:1] != 4'hF;
                  irqLevel <= 3'h7 - {1'b0, addressInterruptIn[1], addressInterruptIn[2]};
                  cpLatched <= {addressInterruptIn[1], addressInterruptIn[2],
                     addressInterruptIn[3], addressInterruptIn[4]};
               end
               if (kind == `K_READ) begin
                  rdata <= dataAddressIn;
               end
               if (kind == `K_INTERRUPT_ACKNOWLEDGE) begin
                  vector <= dataAddressIn;
               end
               priorityInStrobe <= 1'b0;
               columnStrobe_n <= 1'b1;
               rowStrobe_n <= 1'b1;
               writeHighByte_n <= 1'b1;
               writeLowByte_n <= 1'b1;
               // a pending write runs as the second microcycle; dma grant cycles repeat while requested
               if (pendWrite && !micro) begin
                  kind <= `K_WRITE;
                  micro <= 1'b1;
                  pendWrite <= 1'b0;
                  phase <= `PH_1;
               end else if (!granted && addressInterruptIn[0]) begin
                  granted <= 1'b1;
                  phase <= `PH_1;
               end else if (granted && addressInterruptIn[0]) begin
                  phase <= `PH_1;
               end else begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  cycleCode <= 2'b00;
                  phase <= `PH_IDLE;
               end
            end
            default: begin
               // boundary: resolve pending interrupt
               if (req[`REQ_FETCH] && done) begin
                  done <= 1'b0;
                  if (haltPend) begin
                     pc <= `RESTART_DEF;
                     processor_status_word <= `PSW_HALT;
                     haltPend <= 1'b0;
                  end else if (pfPend) begin
                     vector <= `VEC_PF;
                     pfPend <= 1'b0;
                  end else if (irqPend && irqLevel > processor_status_word[7:5]) begin
                     irqPend <= 1'b0;
                     if (!extVec) begin
                        vector <= codedVector(cpLatched);
                     end else begin
                        kind <= `K_INTERRUPT_ACKNOWLEDGE;
                        busy <= 1'b1;
                        phase <= `PH_1;
                     end
                  end
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- bench/bus_iface_monitor.sv
// assertions on the pins of the bus interface block
`timescale 1ns/1ps
`default_nettype none
module bus_iface_monitor (
   // clock and reset
   input wire clk,
   input wire rst,
   // bus pins
   input wire dataAddressOe,
   input wire [7:0] addressInterruptOe,
   input wire addressInterruptPullup,
   input wire rowStrobe_n,
   input wire columnStrobe_n,
   input wire priorityInStrobe,
   input wire writeHighByte_n,
   input wire writeLowByte_n,
   input wire writeControlOe,
   input wire [1:0] cycleCode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire grant = cycleCode == 2'b11;
   a_grant_float: assert property (grant |-> !dataAddressOe && addressInterruptOe == 8'h00)
      else $error("bus driven in grant");
   a_grant_pullup: assert property (grant |-> addressInterruptPullup && !writeControlOe)
      else $error("no pull-up in grant");
   a_code_legal: assert property (cycleCode != 2'b10)
      else $error("illegal cycle code");
   a_fetch_addr: assert property ($fell(rowStrobe_n) && cycleCode == 2'b01 |-> dataAddressOe)
      else $error("fetch address not driven");
   a_col_after_row: assert property ($fell(columnStrobe_n) |-> $past(!rowStrobe_n))
      else $error("column before row");
   a_ucycle_len: assert property ($fell(rowStrobe_n) |-> !rowStrobe_n[*2] ##[1:6] rowStrobe_n)
      else $error("microcycle length");
   a_read_ctl: assert property (priorityInStrobe && !dataAddressOe && !grant
      |-> writeHighByte_n && writeLowByte_n)
      else $error("write control in read");
   a_write_data: assert property ($rose(priorityInStrobe) && !(writeHighByte_n && writeLowByte_n)
      |-> dataAddressOe)
      else $error("write data late");
   c_grant: cover property ($rose(grant));
   c_fetch: cover property ($fell(rowStrobe_n) && cycleCode == 2'b01);
   c_high_byte: cover property (!writeHighByte_n && writeLowByte_n);
endmodule
`default_nettype wire

//--- bench/bus_partner.sv
// far side model: memory, interrupt sources and dma master
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
   // from the block
   input wire clk,
   input wire priorityInStrobe,
   input wire [15:0] dataAddressOut,
   input wire dataAddressOe,
   input wire [7:0] addressInterruptOut,
   input wire [7:0] addressInterruptOe,
   input wire addressInterruptPullup,
   // scenario controls and answers
   input wire [3:0] cpCode,
   input wire [2:0] lineSel_n,
   input wire dmaReq,
   input wire slow,
   input wire [15:0] readWord,
   output wire [15:0] dataAddressIn,
   output wire [7:0] addressInterruptIn,
   output wire ready
);
   reg [15:0] lastDal = 16'h0000;
   reg [7:0] lastAi = 8'h00;
   reg held = 1'b0;
   wire [7:0] req = {lineSel_n, cpCode[0], cpCode[1], cpCode[2], cpCode[3], dmaReq};
   // read data only while the strobe is up, else a changing pattern
   assign dataAddressIn = dataAddressOe ? dataAddressOut
      : priorityInStrobe ? readWord : ~lastDal;
   assign addressInterruptIn = (addressInterruptOe & addressInterruptOut)
      | (~addressInterruptOe & (priorityInStrobe ? req
      : addressInterruptPullup ? 8'hFF : ~lastAi));
   assign ready = !slow || held;
   always @(posedge clk) begin
      lastDal <= dataAddressIn;
      lastAi <= addressInterruptIn;
      held <= priorityInStrobe;
   end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the bus interface block
`timescale 1ns/1ps
`default_nettype none
`include "bus_iface_map.vh"
module testbench;
   reg clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd;
   reg [3:0] cpCode = 4'hF;
   reg [2:0] lineSel_n = 3'h7;
   reg dmaReq = 1'b0, slow = 1'b0, rowPrev = 1'b1, piPrev = 1'b0;
   reg [15:0] readWord = 16'h0000, rowAddr, piData, ev;
   reg [1:0] rowCode, piWr;
   wire [31:0] prdata;
   wire pready, pslverr, dataAddressOe, addressInterruptPullup, rowStrobe_n, columnStrobe_n;
   wire priorityInStrobe, ready, writeHighByte_n, writeLowByte_n, writeControlOe;
   wire [15:0] dataAddressIn, dataAddressOut;
   wire [7:0] addressInterruptIn, addressInterruptOut, addressInterruptOe;
   wire [1:0] cycleCode;
   integer err_total = 0, total_checks = 0, piCnt = 0, piReads = 0, piRun = 0, piLen = 0;
   integer cyc = 0, i, n, r0;
   processor_bus_interface processor_bus_interface_i (.clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .dataAddressIn, .dataAddressOut,
      .dataAddressOe, .addressInterruptIn, .addressInterruptOut, .addressInterruptOe,
      .addressInterruptPullup, .rowStrobe_n, .columnStrobe_n, .priorityInStrobe,
      .writeHighByte_n, .writeLowByte_n, .writeControlOe, .cycleCode, .ready);
   bus_partner bus_partner_i (.clk, .priorityInStrobe, .dataAddressOut, .dataAddressOe,
      .addressInterruptOut, .addressInterruptOe, .addressInterruptPullup, .cpCode,
      .lineSel_n, .dmaReq, .slow, .readWord, .dataAddressIn, .addressInterruptIn, .ready);
   initial begin
      forever #12.5 clk = ~clk;
   end
   // pin observer and timeout
   always @(posedge clk) begin
      rowPrev <= rowStrobe_n;
      piPrev <= priorityInStrobe;
      cyc <= cyc + 1;
      piRun <= priorityInStrobe === 1'b1 ? piRun + 1 : 0;
      if (priorityInStrobe !== 1'b1 && piRun != 0) piLen <= piRun;
      if (rowPrev === 1'b1 && rowStrobe_n === 1'b0) begin
         rowAddr <= dataAddressOut;
         rowCode <= cycleCode;
      end
      if (piPrev === 1'b0 && priorityInStrobe === 1'b1) begin
         piCnt <= piCnt + 1;
         piData <= dataAddressOut;
         piWr <= {writeHighByte_n, writeLowByte_n};
         if (writeHighByte_n & writeLowByte_n) piReads <= piReads + 1;
      end
      if (cyc == 20000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   task chk(input reg ok, input reg [8*14-1:0] msg);
      begin
         total_checks = total_checks + 1;
         if (!ok) begin
            err_total = err_total + 1;
            $display("ERROR %0t %0s", $time, msg);
         end
      end
   endtask
   task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         for (n = 0; pready !== 1'b1 && n < 20; n = n + 1) @(posedge clk);
         rd = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask
   // request a transaction and wait until the pins go quiet
   task run(input reg [31:0] r);
      integer q;
      begin
         apb(1'b1, `REG_REQ, r);
         for (n = 0; rowStrobe_n === 1'b1 && !priorityInStrobe && n < 20; n = n + 1)
            @(posedge clk);
         q = 0;
         for (n = 0; q < 8 && n < 300; n = n + 1) begin
            @(posedge clk);
            q = (rowStrobe_n === 1'b1 && priorityInStrobe === 1'b0) ? q + 1 : 0;
         end
         chk(n < 300, "no finish");
      end
   endtask
   task t_read;
      begin
         readWord <= 16'hA5C3;
         run({12'h001, 1'b1, `K_READ, 16'h1234});
         chk(rowAddr === 16'h1234 && rowCode === 2'b01, "fetch addr");
         chk(piWr === 2'b11, "read ctl");
         apb(1'b0, `REG_DATA, 0);
         chk(rd[15:0] === 16'hA5C3, "read data");
         r0 = piLen;
         apb(1'b1, `REG_CTRL, 32'h2);
         run({13'h0000, `K_READ, 16'h0456});
         chk(piLen == r0 + 1 && rowCode === 2'b00, "long cycle");
         apb(1'b1, `REG_CTRL, 32'h0);
      end
   endtask
   task t_write;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, `REG_DATA, 32'h5A00 + i);
            r0 = piReads;
            run({10'h000, i == 3, i == 1 || i == 2, 1'b0, `K_WRITE, 15'h1000, i == 2});
            chk(rowAddr === {15'h1000, i == 2}, "write addr");
            chk(piData === 16'h5A00 + i[15:0], "write data");
            chk(piWr === (i == 1 ? 2'b10 : i == 2 ? 2'b01 : 2'b00), "byte ctl");
            chk(piReads - r0 == (i == 3 ? 0 : 1), "read first");
         end
      end
   endtask
   task t_vector;
      begin
         for (i = 0; i < 18; i = i + 1) begin
            cpCode <= i > 15 ? 4'hF : i[3:0];
            lineSel_n <= i == 16 ? 3'b101 : i == 17 ? 3'b110 : 3'b111;
            if (i < 15) ev = (i < 4 ? `VEC_B7 : i < 8 ? `VEC_B6 : i < 12 ? `VEC_B5 : `VEC_B4)
               + {i[1:0], 2'b00};
            if (i == 16) ev = `VEC_PF;
            if (i == 17) ev = 16'o310;
            readWord <= 16'o310;
            slow <= i == 17;
            run({13'h0000, i == 17 ? `K_INTERRUPT_ACKNOWLEDGE : `K_PRIORITY_SAMPLE_CYCLE, 16'h0000});
            run({12'h000, 1'b1, `K_READ, 16'h0000});
            apb(1'b0, `REG_VEC, 0);
            chk(rd[15:0] === ev, "vector");
         end
         cpCode <= 4'h0;
         lineSel_n <= 3'b011;
         run({13'h0000, `K_PRIORITY_SAMPLE_CYCLE, 16'h0000});
         run({12'h000, 1'b1, `K_READ, 16'h0000});
         apb(1'b0, `REG_VEC, 0);
         chk(rd[31:16] === `RESTART_DEF, "restart");
         apb(1'b0, `REG_PRIO, 0);
         chk(rd[15:0] === `PSW_HALT, "halt status");
         lineSel_n <= 3'b111;
         cpCode <= 4'hF;
      end
   endtask
   task t_dma;
      begin
         dmaReq <= 1'b1;
         apb(1'b1, `REG_REQ, {13'h0000, `K_READ, 16'h0100});
         for (n = 0; cycleCode !== 2'b11 && n < 60; n = n + 1) @(posedge clk);
         chk(cycleCode === 2'b11 && dataAddressOe === 1'b0, "no grant");
         r0 = piCnt;
         repeat (30) @(posedge clk);
         chk(piCnt > r0 && cycleCode === 2'b11, "grant lost");
         dmaReq <= 1'b0;
         for (n = 0; cycleCode === 2'b11 && n < 60; n = n + 1) @(posedge clk);
         chk(cycleCode !== 2'b11, "grant stuck");
         run({13'h0000, `K_READ, 16'h0300});
         chk(rowAddr === 16'h0300, "resume");
      end
   endtask
   task wrap_up;
      begin
         if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
         end else begin
            $display("CHECKS NOT OK");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(rowStrobe_n === 1'b1 && priorityInStrobe === 1'b0 && cycleCode === 2'b00, "reset");
      apb(1'b0, `REG_CTRL, 0);
      chk(rd === {16'h0000, `CTRL_RST}, "ctrl reset");
      apb(1'b1, 12'h020, 32'hFFFFFFFF);
      apb(1'b0, 12'h020, 0);
      chk(rd === 32'h0, "unmapped");
      t_read;
      t_write;
      t_vector;
      t_dma;
      wrap_up;
   end
endmodule
bind processor_bus_interface bus_iface_monitor bus_iface_monitor_i (.clk, .rst, .dataAddressOe,
   .addressInterruptOe, .addressInterruptPullup, .rowStrobe_n, .columnStrobe_n,
   .priorityInStrobe, .writeHighByte_n, .writeLowByte_n, .writeControlOe, .cycleCode);
`default_nettype wire
